// ---- verification/sbdp_proc_model.sv ----
/*
 holds: behavioural processor on the far side of the data-phase controller.
 assumes: everything happens at rising mclk; the bench calls put and issue.
*/
module sbdp_proc_model (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	output logic             request_start_n,
	output logic             req_lock_len1,
	output logic             req_wr_len0,
	output logic [15:0]      req_addr,
	output logic [63:0]      data_in,
	output logic [7:0]       byte_lane_strobe_n,
	output logic [7:0]       check_bit_lanes_in,
	input  wire logic [63:0] data_out,
	input  wire logic        data_oe_n,
	input  wire logic        data_cycle_valid,
	input  wire logic        critical_word_order
);
	timeunit 1ns;
	timeprecision 100ps;

	logic        w32 = 1'b0;
	logic        pdv = 1'b0;
	logic        pwr = 1'b0;
	logic [1:0]  s1 = 2'h0, s2 = 2'h0;
	logic [63:0] wd;
	logic [7:0]  ws;
	int          rise = 0;
	int          bad = 0;
	logic        tw[$], cq[$];
	int          tb[$], tn[$];
	logic [63:0] wq[$], rq[$];
	logic [7:0]  sq[$];

	initial
	begin
		{request_start_n, req_lock_len1, req_wr_len0} = 3'h4;
		req_addr = 16'h0;
		data_in = 64'h0;
		byte_lane_strobe_n = 8'hFF;
		check_bit_lanes_in = 8'h00;
	end

	function automatic int nbeats(input logic [2:0] len);
		if (len == 3'h6) return w32 ? 8 : 4;
		if (len == 3'h5) return w32 ? 4 : 2;
		if (w32 && len == 3'h4) return 3;
		if (w32 && len == 3'h3) return 2;
		return 1;
	endfunction

	task automatic put(input logic [63:0] d, input logic [7:0] sn);
		wq.push_back(d);
		sq.push_back(sn);
	endtask

	// two-cycle request; keep=0 means the controller is expected to drop it
	task automatic issue(input logic [31:0] a, input logic w, input logic [2:0] len,
		input logic keep);
		logic [31:0] aa;
		aa = (len == 3'h6) ? {a[31:3], 3'h0} : a;
		@(posedge mclk);
		request_start_n <= 1'b0;
		req_lock_len1   <= 1'b0;
		req_wr_len0     <= w;
		req_addr        <= aa[31:16];
		if (keep)
		begin
			tw.push_back(w);
			tb.push_back(nbeats(len));
			tn.push_back(rise);
		end
		@(posedge mclk);
		{request_start_n, req_lock_len1, req_wr_len0} <= len;
		req_addr <= aa[15:0];
		@(posedge mclk);
		{request_start_n, req_lock_len1, req_wr_len0} <= 3'h4;
		req_addr <= ~aa[15:0];
	endtask

	always @(posedge mclk)
	begin
		rise <= rise + 1;
		if (!rst_n)
			w32 <= critical_word_order;
		if (s2 == 2'h2)
		begin
			rq.push_back(data_out);
			if (data_oe_n !== 1'b0)
				bad++;
		end
		if (s1 == 2'h3 && wq.size() > 0)
		begin
			wd = wq.pop_front();
			ws = sq.pop_front();
			data_in <= w32 ? {32'h0, wd[31:0]} : wd;
			byte_lane_strobe_n <= w32 ? {4'hF, ws[3:0]} : ws;
			check_bit_lanes_in <= w32 ? 8'h00 : wd[7:0];
		end
		else
		begin
			data_in <= w32 ? {32'h0, ~data_in[31:0]} : ~data_in;
			byte_lane_strobe_n <= w32 ? {4'hF, ~byte_lane_strobe_n[3:0]} : ~byte_lane_strobe_n;
			check_bit_lanes_in <= w32 ? 8'h00 : ~check_bit_lanes_in;
		end
		s1 <= 2'h0;
		if (data_cycle_valid)
		begin
			if (tw.size() == 0)
				bad++;
			else
			begin
				if (tn[0] >= 0 && rise - tn[0] < 3)
					bad++;
				if (tn[0] >= 0 && !tw[0])
					cq.push_back(critical_word_order);
				if (pdv && pwr != tw[0])
					bad++;
				tn[0] = -1;
				s1 <= {1'b1, tw[0]};
				pwr <= tw[0];
				tb[0] = tb[0] - 1;
				if (tb[0] == 0)
				begin
					tw.delete(0);
					tb.delete(0);
					tn.delete(0);
				end
			end
		end
		pdv <= data_cycle_valid;
		s2 <= s1;
	end
endmodule

// ---- verification/testbench.sv ----
/*
 holds: self-checking bench for the data-phase controller with a processor model.
 assumes: sbdp_cfg.svh on the include path; one AHB-Lite slave.
*/
`include "sbdp_cfg.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hready, hreadyout, mclk_out, dev_reset_n, dcv, cwo, data_oe_n, hresp, cboe;
	logic        req_n, req_l1, req_w0;
	logic [15:0] req_addr;
	logic [63:0] data_in, data_out;
	logic [7:0]  cbi, strb_n, cbo;
	logic [31:0] pat = 32'h1000_0000;
	int          n_errors = 0, check_count = 0;

	assign hready = hreadyout;

	sbdp_host dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mclk_out(mclk_out),
		.dev_reset_n(dev_reset_n), .request_start_n(req_n), .req_lock_len1(req_l1),
		.req_wr_len0(req_w0), .req_addr(req_addr), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .check_bit_lanes_in(cbi), .check_bit_lanes_out(cbo),
		.check_bit_lanes_oe_n(cboe), .byte_lane_strobe_n(strb_n), .data_cycle_valid(dcv),
		.critical_word_order(cwo));

	sbdp_proc_model u_proc (.mclk(mclk_out), .rst_n(dev_reset_n), .request_start_n(req_n),
		.req_lock_len1(req_l1), .req_wr_len0(req_w0), .req_addr(req_addr),
		.data_in(data_in), .byte_lane_strobe_n(strb_n), .check_bit_lanes_in(cbi),
		.data_out(data_out), .data_oe_n(data_oe_n), .data_cycle_valid(dcv),
		.critical_word_order(cwo));

	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		@(posedge clk_sys);
		while (hready !== 1'b1) @(posedge clk_sys);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hready !== 1'b1) @(posedge clk_sys);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check({32'h0, rd}, {32'h0, exp});
	endtask

	task automatic wait_reads(input int n);
		while (u_proc.rq.size() < n) @(posedge clk_sys);
	endtask

	task automatic wait_idle;
		while (u_proc.tw.size() != 0) @(posedge clk_sys);
		repeat (3) @(posedge mclk_out);
		@(posedge clk_sys);
	endtask

	task automatic done(input string name);
		$display("test %s finished, mismatches so far %0d", name, n_errors);
	endtask

	function automatic logic [63:0] pair(input int p);
		return {pat + 32'(2 * p + 1), pat + 32'(2 * p)};
	endfunction

	initial
	begin
		repeat (30000) @(posedge clk_sys);
		n_errors++;
		give_verdict;
	end

	initial
	begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdchk(`SBDP_REG_CTRL, `SBDP_CTRL_RESET);
		rdchk(`SBDP_REG_STATUS, 32'h0);
		rdchk(8'h20, 32'h0);
		bus(1'b1, `SBDP_REG_PATTERN, pat);
		rdchk(`SBDP_REG_PATTERN, pat);
		while (dev_reset_n !== 1'b1) @(posedge clk_sys);
		check(64'(u_proc.w32), 64'h0);
		done("reset");
		u_proc.issue(32'h0000_2408, 1'b0, 3'h2, 1'b1);
		u_proc.issue(32'h0000_2403, 1'b0, 3'h0, 1'b1);
		wait_reads(2);
		check(u_proc.rq[0], pair(1));
		check(u_proc.rq[1], pair(0));
		check(64'(u_proc.cq[0] | u_proc.cq[1]), 64'h0);
		done("single");
		for (int k = 0; k < 5; k++)
		begin
			int u;
			u = (k ^ 6) % 4;
			bus(1'b1, `SBDP_REG_CTRL, (k < 4) ? 32'h3 : 32'h1);
			u_proc.rq.delete();
			u_proc.cq.delete();
			u_proc.issue(32'h3004 + 32'(u) * 8, 1'b0, 3'h6, 1'b1);
			wait_reads(4);
			for (int j = 0; j < 4; j++)
				check(u_proc.rq[j], pair(k < 4 ? (u + j) % 4 : j));
			check(64'(u_proc.cq[0]), 64'(k < 4));
		end
		rdchk(`SBDP_REG_STATUS, 32'h0);
		done("burst");
		bus(1'b1, `SBDP_REG_CTRL, 32'h0);
		u_proc.rq.delete();
		u_proc.put(64'h1111_2222_3333_4444, 8'h00);
		u_proc.put(64'h5555_6666_7777_8888, 8'h00);
		u_proc.issue(32'h2410, 1'b1, 3'h5, 1'b1);
		u_proc.issue(32'h2400, 1'b0, 3'h2, 1'b1);
		u_proc.put(64'h0000_0000_AA00_BB00, 8'hF5);
		u_proc.issue(32'h2400, 1'b1, 3'h2, 1'b1);
		u_proc.put(64'h0123_4567_89AB_CDEF, 8'hF7);
		u_proc.issue(32'h3703, 1'b1, 3'h0, 1'b1);
		u_proc.issue(32'h2800, 1'b0, 3'h2, 1'b0);
		rdchk(`SBDP_REG_STATUS, 32'h0000_0408);
		bus(1'b1, `SBDP_REG_CTRL, 32'h1);
		wait_idle;
		check(u_proc.rq[0], pair(0));
		rdchk(`SBDP_REG_WLO, 32'h89AB_CDEF);
		rdchk(`SBDP_REG_WHI, 32'h0123_4567);
		rdchk(`SBDP_REG_WSTRB, 32'h08);
		bus(1'b1, `SBDP_REG_STATUS, 32'hF);
		@(posedge clk_sys);
		rdchk(`SBDP_REG_STATUS, 32'h0);
		done("pipeline");
		bus(1'b1, `SBDP_REG_CTRL, 32'hD);
		while (dev_reset_n !== 1'b0) @(posedge clk_sys);
		bus(1'b1, `SBDP_REG_CTRL, 32'h7);
		while (dev_reset_n !== 1'b1) @(posedge clk_sys);
		check(64'(u_proc.w32), 64'h1);
		u_proc.rq.delete();
		u_proc.issue(32'h3008, 1'b0, 3'h6, 1'b1);
		u_proc.put(64'hFFFF_FFFF_0000_00A1, 8'hFE);
		u_proc.put(64'h0, 8'hFF);
		u_proc.put(64'h0000_0000_C3C3_C3C3, 8'hF7);
		u_proc.issue(32'h2400, 1'b1, 3'h4, 1'b1);
		wait_idle;
		for (int j = 0; j < 8; j++)
			check(u_proc.rq[j], {32'h0, pat + 32'((j + 2) % 8)});
		rdchk(`SBDP_REG_WLO, 32'hC3C3_C3C3);
		rdchk(`SBDP_REG_WHI, 32'h0);
		rdchk(`SBDP_REG_WSTRB, 32'h08);
		rdchk(`SBDP_REG_STATUS, 32'h0);
		u_proc.put(64'h0, 8'hFF);
		u_proc.put(64'h5A, 8'hFE);
		u_proc.issue(32'h2500, 1'b1, 3'h3, 1'b1);
		wait_idle;
		rdchk(`SBDP_REG_STATUS, 32'h4);
		check(64'(u_proc.bad), 64'h0);
		check({54'h0, hresp, cboe, cbo}, {54'h0, 1'b0, 1'b1, 8'h09});
		done("narrow");
		give_verdict;
	end
endmodule

// ---- verilog/sbdp_cfg.svh ----
/*
 contents: register offsets, field positions, reset values and link timing counts
 for the split bus data-phase controller.
 assumes: included by its bare name from the package and the design modules.
*/
`ifndef SBDP_CFG_SVH
`define SBDP_CFG_SVH

// register byte offsets (low address byte)
`define SBDP_REG_CTRL     8'h00
`define SBDP_REG_STATUS   8'h04
`define SBDP_REG_PATTERN  8'h08
`define SBDP_REG_WLO      8'h0C
`define SBDP_REG_WHI      8'h10
`define SBDP_REG_WSTRB    8'h14
`define SBDP_REG_LADDR    8'h18
`define SBDP_REG_LINFO    8'h1C

// control fields
`define SBDP_CTRL_EN      0
`define SBDP_CTRL_WRAP    1
`define SBDP_CTRL_W32     2
`define SBDP_CTRL_DRST    3
`define SBDP_CTRL_GAP     15:8
`define SBDP_CTRL_RESET   32'h0000_0001

// sticky error bits
`define SBDP_ERR_BOUND    0
`define SBDP_ERR_ALIGN    1
`define SBDP_ERR_STROBE   2
`define SBDP_ERR_OVF      3

// request length codes and spans
`define SBDP_LEN_BURST    3'h6
`define SBDP_WR_SPAN      7'h10
`define SBDP_RD_SPAN      7'h20
`define SBDP_QDEPTH       3'h4

// link clock made by dividing clk_sys
`define SBDP_CLK_NS       10
`define SBDP_LINK_NS      80
`define SBDP_HALF_CNT     2'((`SBDP_LINK_NS / `SBDP_CLK_NS) / 2 - 1)
`define SBDP_STRAP_TICKS  4'h8

`endif

// ---- verilog/sbdp_host.sv ----
/*
 contents: memory-side controller of a split, pipelined processor bus: takes requests,
 paces data cycles with the data-cycle-valid strobe, returns read data, takes write data.
 assumes: the processor on the far side samples on rising mclk_out, which this block makes;
 software drives it through sbdp_regs over AHB-Lite.
*/
`include "sbdp_cfg.svh"

// Notes on behaviour
// - one data transaction per request, completed in request order, any delay.
// - in 64-bit mode each byte sits in its natural lane of the 64-bit block.
// - each data cycle is announced by data-cycle-valid two edges before transfer.
// - on reads the memory side drives all data lines with definite values.
// - an error-correcting slave returns full 64 bits regardless of size.
// - data-cycle-valid comes no earlier than two cycles after request start.
// - burst data cycles may be back-to-back or gapped, and may overlap.
// - critical word order is driven with the first strobe of eight-word reads; here eight-word writes drive it too.
// - order 0 returns sequentially; order 1 starts at requested word, wrapping.
// - 64-bit wrapped order follows address bits 4:3 in word pairs.
// - 32-bit wrapped order follows address bits 4:2 in steps of one word.
// - memory side leaves one idle turnaround between read and write data cycles.
// - at most four requests are outstanding before the first data returns.
module sbdp_host
	import sbdp_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             mclk_out,
	output logic             dev_reset_n,
	input  wire logic        request_start_n,
	input  wire logic        req_lock_len1,
	input  wire logic        req_wr_len0,
	input  wire logic [15:0] req_addr,
	input  wire logic [63:0] data_in,
	output logic [63:0]      data_out,
	output logic             data_oe_n,
	input  wire logic [7:0]  check_bit_lanes_in,
	output logic [7:0]       check_bit_lanes_out,
	output logic             check_bit_lanes_oe_n,
	input  wire logic [7:0]  byte_lane_strobe_n,
	output logic             data_cycle_valid,
	output logic             critical_word_order
);

	sbdp_reg_if    rif ();
	sbdp_host_type s;
	sbdp_host_type next_s;
	sbdp_req_type  head;
	sbdp_req_type  entry;
	sbdp_pins_type pins;
	logic          tick;
	logic          skip;
	logic          push;
	logic          pop;
	logic          lastb;
	logic [3:0]    beats;
	logic [3:0]    eset;
	logic [2:0]    base;
	logic [2:0]    sum;
	logic [2:0]    idx;
	logic [31:0]   pw;
	logic [31:0]   lo;
	logic [7:0]    gap;

	sbdp_regs u_regs (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.rif       (rif)
	);

	always_comb
	begin
		next_s = s;
		pins.req_n = request_start_n;
		pins.lock_len1 = req_lock_len1;
		pins.wr_len0 = req_wr_len0;
		pins.a = req_addr;
		pins.din = data_in;
		pins.strb_n = byte_lane_strobe_n;
		pins.cbits = check_bit_lanes_in;
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		tick = s.mclk && s.phase == `SBDP_HALF_CNT;
		skip = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		eset = 4'h0;
		gap = rif.ctrl[`SBDP_CTRL_GAP];
		head = s.q[s.head];
		entry.addr = {s.hi_a, s.sync2.a};
		entry.wr = s.hi_wr;
		entry.len = {s.sync2.req_n, s.sync2.lock_len1, s.sync2.wr_len0};
		beats = sbdp_beats(head.len, s.w32);
		lastb = {1'b0, s.beat} == beats - 4'h1;
		// start unit: requested word or pair, or unit 0 for sequential bursts
		base = s.w32 ? head.addr[4:2] : {1'b0, head.addr[4:3]};
		if (head.len == `SBDP_LEN_BURST && !rif.ctrl[`SBDP_CTRL_WRAP])
			base = 3'h0;
		sum = base + s.beat;
		idx = s.w32 ? sum : {1'b0, sum[1:0]};
		pw = s.w32 ? {29'h0, s.p2.idx} : {28'h0, s.p2.idx, 1'b0};
		lo = rif.pattern + pw;
		// divider: link clock, state moves on its falling edge
		if (s.phase == `SBDP_HALF_CNT)
		begin
			next_s.phase = 2'h0;
			next_s.mclk = ~s.mclk;
		end
		else
			next_s.phase = s.phase + 2'h1;
		// device reset with width strap on the order pin
		if (rif.ctrl[`SBDP_CTRL_DRST])
			next_s.strap = `SBDP_STRAP_TICKS;
		else if (tick && s.strap != 4'h0)
			next_s.strap = s.strap - 4'h1;
		if (s.strap != 4'h0)
			next_s.w32 = rif.ctrl[`SBDP_CTRL_W32];
		if (tick)
		begin
			next_s.dv = 1'b0;
			next_s.cwo = 1'b0;
			next_s.oe_n = 1'b1;
			next_s.p2 = s.p1;
			next_s.p1 = '0;
			// request: first cycle address high, second cycle length and address low
			if (s.hi_ok)
			begin
				next_s.hi_ok = 1'b0;
				push = 1'b1;
				next_s.laddr = entry.addr;
				next_s.linfo[3:0] = {entry.wr, entry.len};
				if (entry.len == `SBDP_LEN_BURST)
					eset[`SBDP_ERR_ALIGN] = entry.addr[2];
				else if (entry.wr)
					eset[`SBDP_ERR_BOUND] = {3'h0, entry.addr[3:0]}
						+ {1'b0, sbdp_bytes(entry.len)} > `SBDP_WR_SPAN;
				else
					eset[`SBDP_ERR_BOUND] = {2'h0, entry.addr[4:0]}
						+ {1'b0, sbdp_bytes(entry.len)} > `SBDP_RD_SPAN;
			end
			else if (!s.sync2.req_n)
			begin
				next_s.hi_ok = 1'b1;
				next_s.hi_a = s.sync2.a;
				next_s.hi_wr = s.sync2.wr_len0;
				next_s.linfo[4] = s.sync2.lock_len1;
			end
			// data cycle scheduling from the oldest pending request
			if (s.wait_cnt != 8'h0)
				next_s.wait_cnt = s.wait_cnt - 8'h1;
			else if (s.count != 3'h0 && rif.ctrl[`SBDP_CTRL_EN])
			begin
				if (s.dv && s.dv_wr != head.wr)
					skip = 1'b1;
				else
				begin
					next_s.dv = 1'b1;
					next_s.dv_wr = head.wr;
					next_s.cwo = s.beat == 3'h0 && head.len == `SBDP_LEN_BURST
						&& rif.ctrl[`SBDP_CTRL_WRAP];
					next_s.p1.vld = 1'b1;
					next_s.p1.wr = head.wr;
					next_s.p1.first = s.beat == 3'h0;
					next_s.p1.last = lastb;
					next_s.p1.idx = idx;
					if (lastb)
					begin
						pop = 1'b1;
						next_s.beat = 3'h0;
						next_s.wait_cnt = gap;
					end
					else
						next_s.beat = s.beat + 3'h1;
				end
			end
			// transfer two link edges after the strobe
			if (s.p2.vld && !s.p2.wr)
			begin
				next_s.oe_n = 1'b0;
				next_s.dout = {s.w32 ? 32'h0 : lo + 32'h1, lo};
				for (int i = 0; i < 8; i++)
					next_s.cout[i] = ^next_s.dout[8*i+:8];
			end
			if (s.p2.vld && s.p2.wr)
			begin
				next_s.wlo = s.sync2.din[31:0];
				next_s.whi = s.sync2.din[63:32];
				next_s.wstrb = ~s.sync2.strb_n;
				next_s.linfo[12:5] = s.sync2.cbits;
				if ((s.p2.first || s.p2.last) && &s.sync2.strb_n[3:0]
					&& (s.w32 || &s.sync2.strb_n[7:4]))
					eset[`SBDP_ERR_STROBE] = 1'b1;
			end
			// in-order request queue
			if (push)
			begin
				if (s.count == `SBDP_QDEPTH && !pop)
					eset[`SBDP_ERR_OVF] = 1'b1;
				else
				begin
					next_s.q[s.tail] = entry;
					next_s.tail = s.tail + 2'h1;
					if (s.count == 3'h0)
						next_s.wait_cnt = gap;
				end
			end
			next_s.head = s.head + {1'b0, pop};
			next_s.count = s.count + {2'h0, push && !eset[`SBDP_ERR_OVF]} - {2'h0, pop};
		end
		next_s.err = (s.err & ~rif.clear) | eset;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s <= '0;
			s.sync1.req_n <= 1'b1;
			s.sync2.req_n <= 1'b1;
			s.oe_n <= 1'b1;
			s.strap <= `SBDP_STRAP_TICKS;
		end
		else
			s <= next_s;
	end

	assign mclk_out = s.mclk;
	assign dev_reset_n = s.strap == 4'h0;
	assign data_cycle_valid = s.dv;
	assign critical_word_order = s.strap != 4'h0 ? s.w32 : s.cwo;
	assign data_out = s.dout;
	assign data_oe_n = s.oe_n;
	assign check_bit_lanes_out = s.cout;
	assign check_bit_lanes_oe_n = s.oe_n;
	assign rif.err = s.err;
	assign rif.count = s.count;
	assign rif.wlo = s.wlo;
	assign rif.whi = s.whi;
	assign rif.wstrb = s.wstrb;
	assign rif.laddr = s.laddr;
	assign rif.linfo = s.linfo;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_queue_depth: assert property (s.count <= `SBDP_QDEPTH)
		else $error("request queue deeper than four");
	chk_strobe_head: assert property ($rose(data_cycle_valid) |-> $past(s.count) != 3'h0)
		else $error("data strobe without a pending request");
	chk_beat_range: assert property (s.count != 3'h0
		|-> {1'b0, s.beat} < sbdp_beats(s.q[s.head].len, s.w32))
		else $error("beat count beyond transaction length");
	chk_min_wait: assert property (tick && s.hi_ok && s.count == 3'h0 |=> !data_cycle_valid)
		else $error("data strobe too soon after request");
	chk_turn_idle: assert property (tick && s.dv && next_s.dv |-> next_s.dv_wr == s.dv_wr)
		else $error("no turnaround between read and write cycles");
	chk_order_first: assert property (dev_reset_n && critical_word_order
		|-> data_cycle_valid && s.p1.first)
		else $error("order pin outside first strobe");
	chk_read_drive: assert property ($rose(data_cycle_valid) && !s.dv_wr |-> ##16 !data_oe_n)
		else $error("read data not driven two link cycles after strobe");
	chk_burst_index: assert property (tick && s.p1.vld && s.p2.vld && !s.p1.first
		|-> s.p1.idx == ((s.p2.idx + 3'h1) & (s.w32 ? 3'h7 : 3'h3)))
		else $error("burst unit order broken");
	chk_err_sticky: assert property (rif.clear == 4'h0 |=> (s.err & $past(s.err)) == $past(s.err))
		else $error("error flag lost without clear");

	cov_wrap_burst: cover property (tick && s.dv && s.cwo);
	cov_write_take: cover property (tick && s.p2.vld && s.p2.wr);
	cov_turnaround: cover property (tick && skip);
	cov_overflow:   cover property ($rose(s.err[`SBDP_ERR_OVF]));

endmodule

// ---- verilog/sbdp_pkg.sv ----
/*
 contents: types and shared decode functions of the split bus data-phase controller.
 assumes: sbdp_cfg.svh on the include path.
*/
`include "sbdp_cfg.svh"

package sbdp_pkg;

	typedef struct packed {
		logic [31:0] addr;
		logic        wr;
		logic [2:0]  len;
	} sbdp_req_type;

	typedef struct packed {
		logic       vld;
		logic       wr;
		logic       first;
		logic       last;
		logic [2:0] idx;
	} sbdp_beat_type;

	typedef struct packed {
		logic        req_n;
		logic        lock_len1;
		logic        wr_len0;
		logic [15:0] a;
		logic [63:0] din;
		logic [7:0]  strb_n;
		logic [7:0]  cbits;
	} sbdp_pins_type;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] pattern;
		logic        wpend;
		logic [7:0]  waddr;
		logic [31:0] rdata;
		logic [3:0]  clear;
	} sbdp_regs_type;

	typedef struct packed {
		sbdp_pins_type          sync1;
		sbdp_pins_type          sync2;
		logic [1:0]             phase;
		logic                   mclk;
		logic                   hi_ok;
		logic [15:0]            hi_a;
		logic                   hi_wr;
		sbdp_req_type [3:0]     q;
		logic [1:0]             head;
		logic [1:0]             tail;
		logic [2:0]             count;
		logic [2:0]             beat;
		logic [7:0]             wait_cnt;
		sbdp_beat_type          p1;
		sbdp_beat_type          p2;
		logic                   dv;
		logic                   dv_wr;
		logic                   cwo;
		logic                   oe_n;
		logic [63:0]            dout;
		logic [7:0]             cout;
		logic [3:0]             strap;
		logic                   w32;
		logic [3:0]             err;
		logic [31:0]            wlo;
		logic [31:0]            whi;
		logic [7:0]             wstrb;
		logic [31:0]            laddr;
		logic [12:0]            linfo;
	} sbdp_host_type;

	// data cycles of one transaction
	function automatic logic [3:0] sbdp_beats(input logic [2:0] len, input logic w32);
		case (len)
			3'h3:    return w32 ? 4'h2 : 4'h1;
			3'h4:    return w32 ? 4'h3 : 4'h1;
			3'h5:    return w32 ? 4'h4 : 4'h2;
			3'h6:    return w32 ? 4'h8 : 4'h4;
			default: return 4'h1;
		endcase
	endfunction

	// data bytes of one request
	function automatic logic [5:0] sbdp_bytes(input logic [2:0] len);
		case (len)
			3'h0:    return 6'h01;
			3'h1:    return 6'h02;
			3'h2:    return 6'h04;
			3'h3:    return 6'h08;
			3'h4:    return 6'h0C;
			3'h5:    return 6'h10;
			default: return 6'h20;
		endcase
	endfunction

endpackage

// ---- verilog/sbdp_reg_if.sv ----
/*
 contents: interface between the bus register file and the data-phase core.
 assumes: both ends on clk_sys.
*/
interface sbdp_reg_if;
	logic [31:0] ctrl;
	logic [31:0] pattern;
	logic [3:0]  clear;
	logic [3:0]  err;
	logic [2:0]  count;
	logic [31:0] wlo;
	logic [31:0] whi;
	logic [7:0]  wstrb;
	logic [31:0] laddr;
	logic [12:0] linfo;

	modport regs (output ctrl, pattern, clear, input err, count, wlo, whi, wstrb, laddr, linfo);
	modport core (input ctrl, pattern, clear, output err, count, wlo, whi, wstrb, laddr, linfo);
endinterface

// ---- verilog/sbdp_regs.sv ----
/*
 contents: AHB-Lite slave holding the controller's own registers.
 assumes: single slave, word transfers only, clk_sys domain.
*/
`include "sbdp_cfg.svh"

module sbdp_regs
	import sbdp_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	sbdp_reg_if.regs         rif
);

	sbdp_regs_type s;
	sbdp_regs_type next_s;
	logic          acc;

	assign acc = hsel && htrans[1] && hready && hsize == 3'h2;

	always_comb
	begin
		next_s = s;
		next_s.clear = 4'h0;
		if (s.wpend)
		begin
			case (s.waddr)
				`SBDP_REG_CTRL:    next_s.ctrl = hwdata;
				`SBDP_REG_PATTERN: next_s.pattern = hwdata;
				`SBDP_REG_STATUS:  next_s.clear = hwdata[3:0];
				default:           ;
			endcase
		end
		if (hready)
			next_s.wpend = acc && hwrite;
		if (acc)
			next_s.waddr = haddr[7:0];
		if (acc && !hwrite)
		begin
			case (haddr[7:0])
				`SBDP_REG_CTRL:    next_s.rdata = next_s.ctrl;
				`SBDP_REG_STATUS:  next_s.rdata = {21'h0, rif.count, 4'h0, rif.err};
				`SBDP_REG_PATTERN: next_s.rdata = next_s.pattern;
				`SBDP_REG_WLO:     next_s.rdata = rif.wlo;
				`SBDP_REG_WHI:     next_s.rdata = rif.whi;
				`SBDP_REG_WSTRB:   next_s.rdata = {24'h0, rif.wstrb};
				`SBDP_REG_LADDR:   next_s.rdata = rif.laddr;
				`SBDP_REG_LINFO:   next_s.rdata = {16'h0, rif.linfo[12:5], 3'h0, rif.linfo[4:0]};
				default:           next_s.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s <= '0;
			s.ctrl <= `SBDP_CTRL_RESET;
		end
		else
			s <= next_s;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign rif.ctrl = s.ctrl;
	assign rif.pattern = s.pattern;
	assign rif.clear = s.clear;

endmodule
